/* File: bench/acpi_sleep_wake_sva.sv */
/* Checker for the sleep/wake block. Bound to it; sees its ports only. */
`timescale 1ns/1ps
module acpi_sleep_wake_sva
    import acpi_sleep_wake_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire cfg_req_t    cfg_req,
    input wire logic [7:0]  cfg_rdata,
    input wire logic        cfg_rvalid,
    input wire logic        sleep_enable_write,
    input wire logic        enabled_wake_event,
    input wire logic        power_on_request_n,
    input wire sleep_cmd_t  sleep_cmd,
    input wire logic        sleep_write_smi_flag,
    input wire logic        smi_request,
    input wire logic        wake_status,
    input wire logic [7:0]  config_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_sleep_start: assert property (sleep_enable_write && !config_value[0]
        |=> sleep_cmd.start) else $error("sleep did not start");
    a_smi_instead: assert property (sleep_enable_write && config_value[0]
        |=> !sleep_cmd.start && smi_request) else $error("smi path wrong");
    a_flag_set: assert property (sleep_enable_write
        |=> sleep_write_smi_flag) else $error("smi flag not set");
    a_smi_gate: assert property (smi_request
        == (sleep_write_smi_flag && config_value[0])) else $error("smi gate");
    // Pin high four edges: no fall can still be in the synchroniser
    a_pin_only: assert property (power_on_request_n[*4] ##0
        (!config_value[1] && !wake_status) |=> !wake_status)
        else $error("wake status without pin fall");
    a_wake_event: assert property (enabled_wake_event && config_value[1]
        |=> wake_status) else $error("wake event missed");
    a_cfg_write: assert property (cfg_req.write
        && cfg_req.index == SLEEP_WAKE_CONFIG_INDEX |=> config_value
        == ($past(cfg_req.wdata) & SLEEP_WAKE_CONFIG_MASK))
        else $error("config write wrong");
    a_read_back: assert property (cfg_req.read |=> cfg_rvalid
        && cfg_rdata == (($past(cfg_req.index) == SLEEP_WAKE_CONFIG_INDEX)
        ? $past(config_value) : 8'h00)) else $error("read data wrong");
    c_start: cover property (sleep_cmd.start);
    c_smi: cover property (smi_request);
    c_wake: cover property ($rose(wake_status));
endmodule // acpi_sleep_wake_sva
bind acpi_sleep_wake_config acpi_sleep_wake_sva sva (.*);

/* File: bench/tb_acpi_sleep_wake_config.sv */
/* Directed bench for the sleep/wake block; drives every input itself. */
`timescale 1ns/1ps
module tb_acpi_sleep_wake_config import acpi_sleep_wake_pkg::*;;
    logic       clk = 1'h0, rst_n = 1'h0, power_on_request_n = 1'h1;
    logic       sleep_enable_write = 1'h0, sleep_write_smi_clear = 1'h0;
    logic       enabled_wake_event = 1'h0, wake_status_clear = 1'h0;
    logic       cfg_rvalid, smi_request, wake_status, sleep_write_smi_flag;
    logic [2:0] sleep_type_in = 3'h0;
    logic [7:0] cfg_rdata, config_value;
    cfg_req_t   cfg_req = '0;
    sleep_cmd_t sleep_cmd;
    int         mismatches = 0, checks = 0;
    acpi_sleep_wake_config dut (.*);
    always #25 clk = ~clk;
    task automatic chk(input logic [8:0] s, e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] i, d);
        @(posedge clk) cfg_req <= '{1'h1, 1'h0, i, d};
        @(posedge clk) cfg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] e);
        @(posedge clk) cfg_req <= '{1'h0, 1'h1, SLEEP_WAKE_CONFIG_INDEX, '0};
        @(posedge clk) cfg_req <= '0;
        #1 chk({cfg_rvalid, cfg_rdata}, {1'h1, e});
    endtask
    // One strobe pulse; outputs settle just after the taking edge
    task automatic pulse(input logic [3:0] m, input logic [2:0] t);
        @(posedge clk);
        {wake_status_clear, enabled_wake_event} <= m[3:2];
        {sleep_write_smi_clear, sleep_enable_write} <= m[1:0];
        sleep_type_in <= t;
        @(posedge clk);
        {wake_status_clear, enabled_wake_event} <= 2'h0;
        {sleep_write_smi_clear, sleep_enable_write} <= 2'h0;
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #20000 mismatches++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        rd(8'h00);
        wr(8'h10, 8'hff);
        rd(8'h00);
        wr(SLEEP_WAKE_CONFIG_INDEX, 8'hff);
        rd(8'h03);
        wr(SLEEP_WAKE_CONFIG_INDEX, 8'h00);
        pulse(4'h1, 3'h5);
        chk({sleep_cmd, smi_request, sleep_write_smi_flag}, 9'h35);
        pulse(4'h2, 3'h0);
        wr(SLEEP_WAKE_CONFIG_INDEX, 8'h01);
        pulse(4'h1, 3'h2);
        chk({sleep_cmd, smi_request, sleep_write_smi_flag}, 9'h0b);
        wr(SLEEP_WAKE_CONFIG_INDEX, 8'h00);
        pulse(4'h4, 3'h0);
        chk(wake_status, 9'h0);
        @(posedge clk) power_on_request_n <= 1'h0;
        repeat (3) @(posedge clk);
        #1 chk(wake_status, 9'h1);
        pulse(4'h8, 3'h0);
        chk(wake_status, 9'h0);
        wr(SLEEP_WAKE_CONFIG_INDEX, 8'h02);
        pulse(4'h4, 3'h0);
        chk(wake_status, 9'h1);
        conclude();
    end
endmodule // tb_acpi_sleep_wake_config

/* File: hdl/acpi_sleep_wake_config.sv */
/*
 * Sleep/wake configuration block: one configuration register that
 * steers what a write of one to the sleep enable bit does, and which
 * events set the wake status flag.
 * Assumes cfg requests and sleep enable writes come from logic on clk;
 * power_on_request_n is a pin and is synchronised here. rst_n is the
 * battery power-on reset.
 * Assumes the clears and the enabled wake event are single-cycle or
 * level signals on clk, and that whoever consumes sleep_cmd.start and
 * smi_request samples them on clk as well.
 * Assumes a read and a write to the register may share a cycle; the
 * read then answers with the value held before that write.
 */
`timescale 1ns/1ps

// Summary of operation
// - Select 0: sleep enable write starts sleep
// - Select 1: no sleep, raise SMI instead
// - Every sleep enable write sets SMI flag
// - Wake select 0: wake status on power-on fall
// - Wake select 1: also on enabled wake events

module acpi_sleep_wake_config
    import acpi_sleep_wake_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire cfg_req_t                  cfg_req,
    output      logic [CFG_DATA_W-1:0]     cfg_rdata,
    output      logic                      cfg_rvalid,
    input  wire logic                      sleep_enable_write,
    input  wire logic [SLEEP_TYPE_W-1:0]   sleep_type_in,
    input  wire logic                      sleep_write_smi_clear,
    input  wire logic                      enabled_wake_event,
    input  wire logic                      wake_status_clear,
    input  wire logic                      power_on_request_n,
    output      sleep_cmd_t                sleep_cmd,
    output      logic                      sleep_write_smi_flag,
    output      logic                      smi_request,
    output      logic                      wake_status,
    output      logic [CFG_DATA_W-1:0]     config_value
);

    // Elaboration checks: refuse shapes the logic cannot serve
    // Defaults pass; a change that breaks one stops elaboration
    if (SYNC_STAGES < 2) begin : g_sync_stages_check
        $error("SYNC_STAGES must be at least 2");
    end

    if (CFG_DATA_W != $bits(SLEEP_WAKE_CONFIG_MASK)) begin : g_data_w_check
        $error("CFG_DATA_W must match the register mask width");
    end

    if (CFG_INDEX_W != $bits(SLEEP_WAKE_CONFIG_INDEX)) begin : g_index_w_check
        $error("CFG_INDEX_W must match the register index width");
    end

    if (SLEEP_ACTION_SELECT_BIT >= CFG_DATA_W) begin : g_sleep_bit_check
        $error("Sleep action select bit lies outside the register");
    end

    if (WAKE_SOURCE_SELECT_BIT >= CFG_DATA_W) begin : g_wake_bit_check
        $error("Wake source select bit lies outside the register");
    end

    if (SLEEP_ACTION_SELECT_BIT == WAKE_SOURCE_SELECT_BIT) begin : g_sel_apart
        $error("The two select bits must be distinct");
    end

    // Reserved bits must reset to their read value, or breaks
    if ((SLEEP_WAKE_CONFIG_RESET & ~SLEEP_WAKE_CONFIG_MASK)
            != READ_IDLE_DATA) begin : g_reset_check
        $error("Reserved bits must reset to zero");
    end

    // Decoded strobes and held state
    logic [CFG_DATA_W-1:0]     sleep_wake_config;
    logic [CFG_DATA_W-1:0]     write_view;
    logic [CFG_DATA_W-1:0]     read_view;
    logic [SYNC_STAGES-1:0]    power_on_sync;
    logic                      power_on_prev;
    logic                      power_on_fall;
    logic                      sleep_action_select;
    logic                      wake_source_select;
    logic                      config_hit;
    logic                      config_write;
    logic                      config_read;
    logic                      sleep_start;
    logic                      start_pulse;
    logic [SLEEP_TYPE_W-1:0]   held_sleep_type;
    logic                      wake_event_set;
    logic                      wake_set;

    // Register decode; only the one mapped index is written or read back
    assign sleep_action_select = sleep_wake_config[SLEEP_ACTION_SELECT_BIT];
    assign wake_source_select  = sleep_wake_config[WAKE_SOURCE_SELECT_BIT];
    assign config_hit          = (cfg_req.index == SLEEP_WAKE_CONFIG_INDEX);
    assign config_write        = cfg_req.write && config_hit;
    assign config_read         = cfg_req.read && config_hit;
    assign config_value        = read_view;

    // Per bit: implemented bits pass, reserved bits pin to zero
    // Reserved bits cost no storage once the constant flops fold away
    for (genvar b = 0; b < CFG_DATA_W; b++) begin : g_config_bit
        if (SLEEP_WAKE_CONFIG_MASK[b]) begin : g_implemented
            assign write_view[b] = cfg_req.wdata[b];
            assign read_view[b]  = sleep_wake_config[b];
        end else begin : g_reserved
            assign write_view[b] = READ_IDLE_DATA[b];
            assign read_view[b]  = READ_IDLE_DATA[b];
        end
    end

    // Configuration register; reserved bits never store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_wake_config <= SLEEP_WAKE_CONFIG_RESET;
        end else if (config_write) begin
            sleep_wake_config <= write_view;
        end
    end

    // Every read strobe is answered, mapped or not, so no host waits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rvalid <= 1'h0;
        end else begin
            cfg_rvalid <= cfg_req.read;
        end
    end

    // Read data one cycle after the strobe; zero when nothing is read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= READ_IDLE_DATA;
        end else if (config_read) begin
            cfg_rdata <= read_view;
        end else begin
            cfg_rdata <= READ_IDLE_DATA;
        end
    end

    // Sleep start only on the direct route; the SMI route suppresses it
    assign sleep_start = sleep_enable_write && !sleep_action_select;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_pulse <= 1'h0;
        end else begin
            start_pulse <= sleep_start;
        end
    end

    // Type kept from the last write; a late sequencer still sees it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_sleep_type <= '0;
        end else if (sleep_enable_write) begin
            held_sleep_type <= sleep_type_in;
        end
    end

    // Both fields leave from flops; the consumer sees no glitch
    assign sleep_cmd = '{start: start_pulse, sleep_type: held_sleep_type};

    // Sticky flag; a new write beats a clear in the same cycle
    // The flag records every write; the select bit only gates the SMI
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_write_smi_flag <= 1'h0;
        end else if (sleep_enable_write) begin
            sleep_write_smi_flag <= 1'h1;
        end else if (sleep_write_smi_clear) begin
            sleep_write_smi_flag <= 1'h0;
        end
    end

    // SMI only while the flag is set and the select bit routes it
    assign smi_request = sleep_write_smi_flag && sleep_action_select;

    // Pin synchroniser; resets to idle so release makes no false edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_on_sync <= {SYNC_STAGES{POWER_ON_IDLE}};
        end else begin
            power_on_sync <= {power_on_sync[SYNC_STAGES-2:0],
                              power_on_request_n};
        end
    end

    // Edge memory reads the last stage only, never the raw pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_on_prev <= POWER_ON_IDLE;
        end else begin
            power_on_prev <= power_on_sync[SYNC_STAGES-1];
        end
    end

    assign power_on_fall = power_on_prev && !power_on_sync[SYNC_STAGES-1];

    // Wake events count only when the wake select bit routes them
    assign wake_event_set = wake_source_select && enabled_wake_event;
    assign wake_set       = power_on_fall
                         || wake_event_set;

    // Wake status; set beats clear in the same cycle
    // A clear that meets a fresh event loses, so no wake is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_status <= 1'h0;
        end else if (wake_set) begin
            wake_status <= 1'h1;
        end else if (wake_status_clear) begin
            wake_status <= 1'h0;
        end
    end

endmodule // acpi_sleep_wake_config

/* File: hdl/acpi_sleep_wake_pkg.sv */
/*
 * Constants and types for the sleep/wake configuration block:
 * register index, field positions, reset value, carrier structs.
 * Assumes an 8-bit configuration index/data path from the host side.
 */
package acpi_sleep_wake_pkg;

    localparam int          CFG_INDEX_W        = 8;
    localparam int          CFG_DATA_W         = 8;
    localparam int          SLEEP_TYPE_W       = 3;

    localparam logic [7:0]  SLEEP_WAKE_CONFIG_INDEX = 8'hf0;
    localparam logic [7:0]  SLEEP_WAKE_CONFIG_RESET = 8'h00;
    localparam int          SLEEP_ACTION_SELECT_BIT = 0;
    localparam int          WAKE_SOURCE_SELECT_BIT  = 1;
    localparam logic [7:0]  SLEEP_WAKE_CONFIG_MASK  = 8'h03;
    localparam logic [7:0]  READ_IDLE_DATA          = 8'h00;

    // Idle level of the active-low power-on request line
    localparam logic        POWER_ON_IDLE      = 1'h1;

    typedef struct packed {
        logic                      write;
        logic                      read;
        logic [CFG_INDEX_W-1:0]    index;
        logic [CFG_DATA_W-1:0]     wdata;
    } cfg_req_t;

    typedef struct packed {
        logic                      start;
        logic [SLEEP_TYPE_W-1:0]   sleep_type;
    } sleep_cmd_t;

endpackage
